/* inc/ccc_params.svh */
`ifndef CCC_PARAMS_SVH
`define CCC_PARAMS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define CCC_IDX_CH2_OFS_HI  6'h14
`define CCC_IDX_CH2_OFS_LO  6'h15
`define CCC_IDX_CH2_GAIN_HI 6'h16
`define CCC_IDX_CH2_GAIN_LO 6'h17
`define CCC_IDX_CH3_CONFIG     6'h18
`define CCC_IDX_CH3_OFS_HI  6'h19
`define CCC_IDX_CH3_OFS_LO  6'h1a

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCC_RST_OFS_HI      16'h0000
`define CCC_RST_GAIN_HI     16'h8000
`define CCC_RST_LOW_BYTE    8'h00
`define CCC_RST_PHASE       10'h000
`define CCC_RST_DC_DIS      1'b0
`define CCC_RST_RDATA       32'h0000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCC_LOW_MSB         15
`define CCC_LOW_LSB         8
`define CCC_PHASE_MSB       15
`define CCC_PHASE_LSB       6
`define CCC_PHASE_SPLIT     2
`define CCC_DC_DIS_BIT      2
`define CCC_SEL_MSB         1
`define CCC_SEL_LSB         0
`define CCC_ADDR_IDX_MSB    7
`define CCC_ADDR_IDX_LSB    2

`endif

/* inc/ccc_pkg.sv */
package ccc_pkg;

  // Channel 3 input selection encoding
  typedef enum logic [1:0] {
    CCC_SEL_PINS,
    CCC_SEL_SHORT,
    CCC_SEL_POS_DC,
    CCC_SEL_NEG_DC
  } ccc_in_sel_t;

  // Bus answer states
  typedef enum logic {
    CCC_BUS_IDLE,
    CCC_BUS_ACK
  } ccc_bus_state_t;

endpackage

/* core/ccc_avmm_slave.sv */
`timescale 1ns/1ps

module ccc_avmm_slave
  import ccc_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic bus_read,
  input  wire logic bus_write,
  output logic      bus_waitrequest,
  output logic      take,
  output logic      ack
);

  ccc_bus_state_t state_q;
  ccc_bus_state_t state_d;

  // ----------------------------------------------------------------
  // Handshake: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      CCC_BUS_IDLE: begin
        if (bus_read || bus_write) begin
          state_d = CCC_BUS_ACK;
        end
      end
      CCC_BUS_ACK: begin
        state_d = CCC_BUS_IDLE;
      end
      default: begin
        state_d = CCC_BUS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= CCC_BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Request seen while idle, and answer cycle
  assign take            = (state_q == CCC_BUS_IDLE) && (bus_read || bus_write);
  assign ack             = (state_q == CCC_BUS_ACK);
  assign bus_waitrequest = !ack;

endmodule

/* core/ccc_cal_word.sv */
`timescale 1ns/1ps

module ccc_cal_word (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [15:0] upper,
  input  wire logic [7:0]  lower,
  input  wire logic [23:0] reset_word,
  output logic      [23:0] word
);

  // Joined correction word, registered for the datapath
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      word <= reset_word;
    end else begin
      word <= {upper, lower};
    end
  end

endmodule

/* core/ccc_regs.sv */
// Behaviour
// RL1: Ch2 offset bits 23:8, read/write, reset zero
// RL2: Ch2 offset low byte; bits 7:0 read zero
// RL3: Ch2 gain bits 23:8, reset 8000h
// RL4: Ch2 gain low byte, reset zero, reserved zero
// RL5: Ch3 phase delay, 10-bit signed, bits 15:6
// RL6: Ch3 config bits 5:3 read zero
// RL7: Ch3 DC filter disable overrides global setting
// RL8: Ch3 input select: pins, short, +DC, -DC
// RL9: Ch3 offset bits 23:8, read/write, reset zero
// RL10: Correction word is upper register plus byte
`timescale 1ns/1ps

`include "ccc_params.svh"

module ccc_regs (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic [7:0]         AVS_ADDRESS,
  input  wire logic               AVS_READ,
  input  wire logic               AVS_WRITE,
  input  wire logic [31:0]        AVS_WRITEDATA,
  input  wire logic [3:0]         AVS_BYTEENABLE,
  output logic      [31:0]        AVS_READDATA,
  output logic                    AVS_WAITREQUEST,
  input  wire logic               GLOBAL_DC_FILTER_SETTING,
  output logic      [23:0]        CH2_OFFSET_WORD,
  output logic      [23:0]        CH2_GAIN_WORD,
  output logic      [23:0]        CH3_OFFSET_WORD,
  output logic      [9:0]         CH3_PHASE_DELAY,
  output logic                    CH3_DC_FILTER_DISABLE,
  output logic                    CH3_DC_FILTER_ACTIVE,
  output ccc_pkg::ccc_in_sel_t    CH3_INPUT_SELECT,
  output logic                    CH3_INPUTS_SHORTED,
  output logic                    CH3_TEST_ENABLE,
  output logic                    CH3_TEST_NEGATIVE
);

  import ccc_pkg::*;

  // ----------------------------------------------------------------
  // Calibration pair table: 0 = ch2 offset, 1 = ch2 gain, 2 = ch3 offset
  // ----------------------------------------------------------------
  localparam int NUM_CAL = 3;

  // Index of each upper half
  localparam logic [5:0] HI_IDX [NUM_CAL] = '{
    `CCC_IDX_CH2_OFS_HI, `CCC_IDX_CH2_GAIN_HI, `CCC_IDX_CH3_OFS_HI
  };
  // Index of each lower half
  localparam logic [5:0] LO_IDX [NUM_CAL] = '{
    `CCC_IDX_CH2_OFS_LO, `CCC_IDX_CH2_GAIN_LO, `CCC_IDX_CH3_OFS_LO
  };
  // Reset value of each upper half
  localparam logic [15:0] HI_RST [NUM_CAL] = '{
    `CCC_RST_OFS_HI, `CCC_RST_GAIN_HI, `CCC_RST_OFS_HI
  };

  // Bus side
  logic        take;
  logic        ack;
  logic [5:0]  idx;
  logic        aligned;
  logic        wr_en;
  logic [15:0] wdata;
  logic [1:0]  be;
  logic [31:0] rdata_d;

  // Calibration storage
  logic [15:0] hi_q [NUM_CAL];
  logic [7:0]  lo_q [NUM_CAL];
  logic [23:0] word [NUM_CAL];

  // Channel 3 storage and decoded flags
  logic [9:0]  phase_q;
  logic        dc_dis_q;
  ccc_in_sel_t sel_q;
  logic        dc_active_q;
  logic        short_q;
  logic        test_en_q;
  logic        test_neg_q;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // One wait state per access; waitrequest drops only in the answer cycle
  ccc_avmm_slave u_slave (
    .CLK             (CLK),
    .RST_N           (RST_N),
    .bus_read        (AVS_READ),
    .bus_write       (AVS_WRITE),
    .bus_waitrequest (AVS_WAITREQUEST),
    .take            (take),
    .ack             (ack)
  );

  // ----------------------------------------------------------------
  // Address decode and write strobe
  // ----------------------------------------------------------------
  // Address decode; unaligned byte addresses map to nothing
  // Byte lanes 3:2 and data bits 31:16 reach no register field
  assign idx     = AVS_ADDRESS[`CCC_ADDR_IDX_MSB:`CCC_ADDR_IDX_LSB];
  assign aligned = (AVS_ADDRESS[1:0] == 2'h0);
  assign wdata   = AVS_WRITEDATA[15:0];
  assign be      = AVS_BYTEENABLE[1:0];

  // Write lands on the edge where waitrequest is low
  // The take edge only starts the wait; nothing is written there
  assign wr_en   = ack && AVS_WRITE && aligned;

  // ----------------------------------------------------------------
  // Calibration register pairs
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CAL; gi++) begin : g_cal
      // Each half updates on its own write; software writes the upper
      // half first, since the joined word shows a mix for one access
      // RL1: upper word store
      // RL3: gain upper reset
      // RL9: ch3 upper store
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          hi_q[gi] <= HI_RST[gi];
        end else if (wr_en && (idx == HI_IDX[gi])) begin
          if (be[0]) begin
            hi_q[gi][7:0] <= wdata[7:0];
          end
          if (be[1]) begin
            hi_q[gi][15:8] <= wdata[15:8];
          end
        end
      end

      // RL2: low byte store
      // RL4: gain low byte
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          lo_q[gi] <= `CCC_RST_LOW_BYTE;
        end else if (wr_en && (idx == LO_IDX[gi]) && be[1]) begin
          lo_q[gi] <= wdata[`CCC_LOW_MSB:`CCC_LOW_LSB];
        end
      end

      // RL10: join correction word
      ccc_cal_word u_word (
        .CLK        (CLK),
        .RST_N      (RST_N),
        .upper      (hi_q[gi]),
        .lower      (lo_q[gi]),
        .reset_word ({HI_RST[gi], `CCC_RST_LOW_BYTE}),
        .word       (word[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Correction word outputs
  // ----------------------------------------------------------------
  // Words trail their registers by one clock
  assign CH2_OFFSET_WORD = word[0];
  assign CH2_GAIN_WORD   = word[1];
  assign CH3_OFFSET_WORD = word[2];

  // ----------------------------------------------------------------
  // Channel 3 configuration
  // ----------------------------------------------------------------
  // Phase field straddles both byte lanes; each lane writes its own bits
  // RL5: phase delay store
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      phase_q <= `CCC_RST_PHASE;
    end else if (wr_en && (idx == `CCC_IDX_CH3_CONFIG)) begin
      if (be[1]) begin
        phase_q[9:`CCC_PHASE_SPLIT] <= wdata[15:8];
      end
      if (be[0]) begin
        phase_q[`CCC_PHASE_SPLIT-1:0] <= wdata[7:`CCC_PHASE_LSB];
      end
    end
  end

  // Bit 2 is the only writable bit between select and phase fields
  // RL7: channel filter disable
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dc_dis_q <= `CCC_RST_DC_DIS;
    end else if (wr_en && (idx == `CCC_IDX_CH3_CONFIG) && be[0]) begin
      dc_dis_q <= wdata[`CCC_DC_DIS_BIT];
    end
  end

  // All four codes are legal, so the field is stored as written
  // RL8: input select store
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sel_q <= CCC_SEL_PINS;
    end else if (wr_en && (idx == `CCC_IDX_CH3_CONFIG) && be[0]) begin
      sel_q <= ccc_in_sel_t'(wdata[`CCC_SEL_MSB:`CCC_SEL_LSB]);
    end
  end

  // ----------------------------------------------------------------
  // Channel 3 derived controls
  // ----------------------------------------------------------------
  // Decoded controls are registered so the datapath sees one clean level
  // per cycle; they trail the stored fields by one clock

  // RL7: filter follows global unless disabled
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dc_active_q <= 1'b0;
    end else begin
      dc_active_q <= GLOBAL_DC_FILTER_SETTING && !dc_dis_q;
    end
  end

  // Codes are exhaustive; the default only catches unknown values
  // RL8: decode input source
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      short_q    <= 1'b0;
      test_en_q  <= 1'b0;
      test_neg_q <= 1'b0;
    end else begin
      case (sel_q)
        CCC_SEL_PINS: begin
          short_q    <= 1'b0;
          test_en_q  <= 1'b0;
          test_neg_q <= 1'b0;
        end
        CCC_SEL_SHORT: begin
          short_q    <= 1'b1;
          test_en_q  <= 1'b0;
          test_neg_q <= 1'b0;
        end
        CCC_SEL_POS_DC: begin
          short_q    <= 1'b0;
          test_en_q  <= 1'b1;
          test_neg_q <= 1'b0;
        end
        CCC_SEL_NEG_DC: begin
          short_q    <= 1'b0;
          test_en_q  <= 1'b1;
          test_neg_q <= 1'b1;
        end
        default: begin
          short_q    <= 1'b0;
          test_en_q  <= 1'b0;
          test_neg_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channel 3 outputs
  // ----------------------------------------------------------------
  // Configuration fields drive the pins straight from their registers
  assign CH3_PHASE_DELAY       = phase_q;
  assign CH3_DC_FILTER_DISABLE = dc_dis_q;
  assign CH3_DC_FILTER_ACTIVE  = dc_active_q;
  assign CH3_INPUT_SELECT      = sel_q;
  assign CH3_INPUTS_SHORTED    = short_q;
  assign CH3_TEST_ENABLE       = test_en_q;
  assign CH3_TEST_NEGATIVE     = test_neg_q;

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  // Readback mux; unmapped and reserved bits give zero
  // Register indexes are unique, so at most one match drives each bit
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (aligned) begin
      for (int i = 0; i < NUM_CAL; i++) begin
        if (idx == HI_IDX[i]) begin
          rdata_d[15:0] = hi_q[i];
        end
        // RL2: reserved low byte zero
        if (idx == LO_IDX[i]) begin
          rdata_d[`CCC_LOW_MSB:`CCC_LOW_LSB] = lo_q[i];
        end
      end
      // RL6: reserved bits zero
      if (idx == `CCC_IDX_CH3_CONFIG) begin
        rdata_d[`CCC_PHASE_MSB:`CCC_PHASE_LSB] = phase_q;
        rdata_d[`CCC_DC_DIS_BIT]               = dc_dis_q;
        rdata_d[`CCC_SEL_MSB:`CCC_SEL_LSB]     = sel_q;
      end
    end
  end

  // No write can land between take and answer, so early capture is safe
  // Read data captured when the request is taken, stands until next read
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      AVS_READDATA <= `CCC_RST_RDATA;
    end else if (take && AVS_READ) begin
      AVS_READDATA <= rdata_d;
    end
  end

endmodule

/* verification/ccc_regs_assertions.sv */
`timescale 1ns/1ps

module ccc_regs_chk
  import ccc_pkg::*;
(
  input wire logic                 CLK,
  input wire logic                 RST_N,
  input wire logic [7:0]           AVS_ADDRESS,
  input wire logic                 AVS_READ,
  input wire logic                 AVS_WRITE,
  input wire logic [31:0]          AVS_READDATA,
  input wire logic                 AVS_WAITREQUEST,
  input wire logic                 GLOBAL_DC_FILTER_SETTING,
  input wire logic [23:0]          CH2_OFFSET_WORD,
  input wire logic [23:0]          CH2_GAIN_WORD,
  input wire logic [23:0]          CH3_OFFSET_WORD,
  input wire logic [9:0]           CH3_PHASE_DELAY,
  input wire logic                 CH3_DC_FILTER_DISABLE,
  input wire logic                 CH3_DC_FILTER_ACTIVE,
  input wire ccc_pkg::ccc_in_sel_t CH3_INPUT_SELECT,
  input wire logic                 CH3_INPUTS_SHORTED,
  input wire logic                 CH3_TEST_ENABLE,
  input wire logic                 CH3_TEST_NEGATIVE
);
  // ------------------------------------------------------------
  // Bus handshake and register relations
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire rd_ans = AVS_READ && !AVS_WAITREQUEST; // Read answer cycle

  chk_wait_one: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered after one wait state");
  chk_gain_reset: assert property ($rose(RST_N) |-> CH2_GAIN_WORD == 24'h800000)
    else $error("gain word reset value wrong");
  chk_offset_reset: assert property ($rose(RST_N) |-> CH2_OFFSET_WORD == 24'h0 && CH3_OFFSET_WORD == 24'h0)
    else $error("offset word reset value wrong");
  chk_active_map: assert property ($past(RST_N) |->
    CH3_DC_FILTER_ACTIVE == ($past(GLOBAL_DC_FILTER_SETTING) && !$past(CH3_DC_FILTER_DISABLE)))
    else $error("filter active flag wrong");
  chk_short_decode: assert property ($past(RST_N) |->
    CH3_INPUTS_SHORTED == ($past(CH3_INPUT_SELECT) == CCC_SEL_SHORT))
    else $error("shorted flag wrong");
  chk_test_decode: assert property ($past(RST_N) |-> CH3_TEST_ENABLE == $past(CH3_INPUT_SELECT[1])
    && CH3_TEST_NEGATIVE == ($past(CH3_INPUT_SELECT) == CCC_SEL_NEG_DC))
    else $error("test signal flags wrong");
  chk_cfg_readback: assert property (rd_ans && AVS_ADDRESS == 8'h60 |->
    AVS_READDATA == {16'h0, CH3_PHASE_DELAY, 3'b000, CH3_DC_FILTER_DISABLE, CH3_INPUT_SELECT})
    else $error("config read data wrong");
  chk_low_readback: assert property (rd_ans && AVS_ADDRESS == 8'h54 |->
    AVS_READDATA == {16'h0, CH2_OFFSET_WORD[7:0], 8'h00})
    else $error("offset low read data wrong");
endmodule

bind ccc_regs ccc_regs_chk ccc_regs_chk_inst (.*);

/* verification/ccc_regs_tb.sv */
`timescale 1ns/1ps

module ccc_regs_tb;
  import ccc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [31:0] e;} ccc_row_t;
  logic        CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, GLOBAL_DC_FILTER_SETTING;
  logic [7:0]  AVS_ADDRESS;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [23:0] CH2_OFFSET_WORD, CH2_GAIN_WORD, CH3_OFFSET_WORD;
  logic [9:0]  CH3_PHASE_DELAY;
  logic        CH3_DC_FILTER_DISABLE, CH3_DC_FILTER_ACTIVE, CH3_INPUTS_SHORTED, CH3_TEST_ENABLE, CH3_TEST_NEGATIVE;
  ccc_in_sel_t CH3_INPUT_SELECT;
  int          miscompares, checks, cycles = 0;
  // Write value and expected read back, unmapped and unaligned last
  ccc_row_t    rows [9] = '{'{8'h50, 16'ha5c3, 32'ha5c3}, '{8'h54, 16'hffff, 32'hff00},
    '{8'h58, 16'h1234, 32'h1234}, '{8'h5c, 16'hffff, 32'hff00}, '{8'h60, 16'hffff, 32'hffc7},
    '{8'h64, 16'h8001, 32'h8001}, '{8'h68, 16'hffff, 32'hff00}, '{8'h6c, 16'hffff, 32'h0},
    '{8'h51, 16'hffff, 32'h0}};

  ccc_regs ccc_regs_inst (.*);

  // ------------------------------------------------------------
  // Clock, timeout and helpers
  // ------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // Cut a hung bus wait short
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic wr, input logic [15:0] d, input logic [3:0] be);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {16'h0, d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK); // Idle edge keeps the next request off this time step
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {RST_N, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE} = '0;
    GLOBAL_DC_FILTER_SETTING = 1'b1;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    // Write then read back each row
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].d, 4'h3);
      bus(rows[i].a, 1'b0, 16'h0, 4'h3);
      chk(rd, rows[i].e);
    end
    repeat (2) @(posedge CLK);
    chk(CH2_OFFSET_WORD, 24'ha5c3ff);
    chk(CH2_GAIN_WORD, 24'h1234ff);
    chk(CH3_OFFSET_WORD, 24'h8001ff);
    chk({CH3_PHASE_DELAY, CH3_DC_FILTER_DISABLE, CH3_DC_FILTER_ACTIVE}, {10'h3ff, 2'b10});
    $display("table test done");
    // Every input select code, low byte only, reserved bits written high
    for (int s = 0; s < 4; s++) begin
      bus(8'h60, 1'b1, {8'h55, 6'b001110, s[1:0]}, 4'h1);
      bus(8'h60, 1'b0, 16'h0, 4'h3);
      chk(rd, {16'h0, 14'h3fc0, s[1:0]});
      repeat (2) @(posedge CLK);
      chk({CH3_INPUTS_SHORTED, CH3_TEST_ENABLE, CH3_TEST_NEGATIVE}, {s == 1, s[1], s == 3});
      chk(CH3_DC_FILTER_ACTIVE, 1'b1);
    end
    GLOBAL_DC_FILTER_SETTING <= 1'b0;
    repeat (2) @(posedge CLK);
    chk(CH3_DC_FILTER_ACTIVE, 1'b0);
    $display("select test done");
    // Reset in mid-run restores defaults
    RST_N <= 1'b0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    chk({CH2_GAIN_WORD, CH3_PHASE_DELAY}, {24'h800000, 10'h0});
    bus(8'h58, 1'b0, 16'h0, 4'h3);
    chk(rd, 32'h8000);
    bus(8'h54, 1'b0, 16'h0, 4'h3);
    chk(rd, 32'h0);
    $display("reset test done");
    // Each byte lane writes only its own half; reserved low byte stays zero
    bus(8'h50, 1'b1, 16'h1111, 4'h1);
    bus(8'h50, 1'b1, 16'h2222, 4'h2);
    bus(8'h50, 1'b0, 16'h0, 4'h3);
    chk(rd, 32'h2211);
    bus(8'h54, 1'b1, 16'h3344, 4'h1);
    bus(8'h54, 1'b0, 16'h0, 4'h3);
    chk(rd, 32'h0);
    $display("lane test done");
    report_and_stop();
  end
endmodule
